// >>> dv/port_pin_control_test.sv
/*
 * Self-checking bench for the port pin control block.
 * Assumes ppc_pkg and the pin model are compiled first; one clock.
 */
`default_nettype none
module port_pin_control_test
	import ppc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, sys_rst, hsel, hwrite, ke, ee;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, op_mode;
	logic hrdy, hresp, irq, ecl_o, ecl_oe, rdj, rdh;
	logic [7:0] j_ext, e_ext, j_in, k_in, e_in, alt;
	logic [7:0] j_out, j_oe, j_pu, j_pd, k_out, k_oe, e_out, e_oe, e_pu;
	int n_fail = 0;
	int cmp_count = 0;

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	ppc_port_ctrl uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
		.hreadyout(hrdy), .hresp(hresp), .op_mode(op_mode),
		.page_index_emul_enable(ke), .eport_emul_enable(ee),
		.jport_in(j_in), .jport_out(j_out), .jport_oe(j_oe),
		.jport_pull_on(j_pu), .jport_pull_down(j_pd),
		.jport_reduced_drive(rdj), .hport_reduced_drive(rdh),
		.jport_wake_irq(irq), .kport_in(k_in), .kport_out(k_out),
		.kport_oe(k_oe), .emul_chip_select(alt[6]),
		.page_index(alt[7:5]), .eport_in(e_in), .eport_out(e_out),
		.eport_oe(e_oe), .eport_pull_on(e_pu), .data_enable_pin(alt[0]),
		.calibration_sig(alt[1]), .clock_test_sig(alt[2]),
		.pipe_status(alt[4:3]), .e_clock_sig(alt[5]),
		.e_clock_out(ecl_o), .e_clock_oe(ecl_oe)
	);

	ppc_pin_model pins_m (
		.core_clk(core_clk), .j_out(j_out), .j_oe(j_oe), .j_ext(j_ext),
		.k_out(k_out), .k_oe(k_oe), .e_out(e_out), .e_oe(e_oe),
		.e_ext(e_ext), .j_pin(j_in), .k_pin(k_in), .e_pin(e_in),
		.alt(alt)
	);

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Bounded wait: a stuck slave ends the run instead of hanging
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hrdy !== 1'b1 && n < 16);
		if (hrdy !== 1'b1) begin
			n_fail++;
			$display("[ERR] hready expected 1 seen %b", hrdy);
			close_out();
		end
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_rdy();
		q = hrdata[7:0];
		chk("hresp", 8'h00, {7'h00, hresp});
	endtask : bus

	function automatic logic [31:0] ad(input logic [7:0] i);
		return {22'h000000, i, 2'h0};
	endfunction : ad

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, ad(i), d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] i,
		input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, ad(i), 8'h00, q);
		chk(nm, e, q);
	endtask : rdc

	// Mode is only sampled cleanly across a reset
	task automatic do_reset(input logic [2:0] m, input logic k,
		input logic e);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		op_mode <= m;
		ke <= k;
		ee <= e;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
	endtask : do_reset

	task automatic t_reg();
		logic [7:0] q;
		rdc("edir_rst", IDX_EDIR, 8'h00);
		chk("j_oe_rst", 8'h00, j_oe);
		chk("j_pd_rst", 8'h00, j_pd);
		wr(IDX_EDIR, 8'hFF);
		rdc("edir_low", IDX_EDIR, 8'hFC);
		chk("e_oe_low", 8'h00, e_oe & 8'h03);
		bus(1'b0, ad(IDX_EDATA), 8'h00, q);
		chk("e_irq_pins", 8'h03, q & 8'h03);
		wr(IDX_EDIR, 8'h84);
		wr(IDX_PULL, 8'h10);
		@(negedge core_clk);
		chk("e_pull", 8'h0B, e_pu);
		wr(IDX_RDRV, 8'h02);
		wr(IDX_RDRV, 8'h01);
		rdc("rdrv_once", IDX_RDRV, 8'h02);
		chk("rdrv_pins", 8'h02, {6'h00, rdj, rdh});
		bus(1'b1, 32'h00000400, 8'hFF, q);
		bus(1'b0, 32'h00000400, 8'h00, q);
		chk("unmapped", 8'h00, q);
		wr(IDX_EASSIGN, 8'hD0);
		rdc("ea_norm1", IDX_EASSIGN, 8'h90);
		wr(IDX_EASSIGN, 8'h08);
		rdc("ea_norm2", IDX_EASSIGN, 8'h98);
		@(negedge core_clk);
		chk("e_clk_off", 8'h00, {7'h00, ecl_o});
		chk("pe7_cal", {7'h00, alt[1]}, {7'h00, e_out[7]});
		$display("test registers done");
	endtask : t_reg

	task automatic t_jport();
		wr(IDX_JPOL, 8'h01);
		wr(IDX_JDIR, 8'h0F);
		wr(IDX_JFLAG, 8'hFF);
		wr(IDX_JIEN, 8'h01);
		repeat (3) @(negedge core_clk);
		chk("j_oe", 8'h0F, j_oe);
		chk("irq_idle", 8'h00, {7'h00, irq});
		wr(IDX_JDATA, 8'h01);
		repeat (3) @(negedge core_clk);
		chk("irq_rise_out", 8'h01, {7'h00, irq});
		wr(IDX_JFLAG, 8'hFF);
		j_ext <= 8'hEF;
		repeat (3) @(negedge core_clk);
		chk("irq_masked", 8'h00, {7'h00, irq});
		wr(IDX_JIEN, 8'h11);
		@(negedge core_clk);
		chk("irq_fall", 8'h01, {7'h00, irq});
		wr(IDX_PULL, 8'h80);
		@(negedge core_clk);
		chk("j_pull_on", 8'hF0, j_pu);
		chk("j_pull_dn", 8'h01, j_pd);
		$display("test port j done");
	endtask : t_jport

	task automatic t_spec();
		do_reset(MODE_SPEC_SINGLE, 1'b0, 1'b0);
		wr(IDX_EASSIGN, 8'hD0);
		rdc("ea_spec1", IDX_EASSIGN, 8'h10);
		wr(IDX_EASSIGN, 8'hC0);
		rdc("ea_spec2", IDX_EASSIGN, 8'hC0);
		@(negedge core_clk);
		chk("e_clk", {6'h00, 1'b1, alt[5]}, {6'h00, ecl_oe, ecl_o});
		do_reset(MODE_SPEC_EXP, 1'b0, 1'b0);
		wr(IDX_EASSIGN, 8'h40);
		wr(IDX_EASSIGN, 8'h40);
		@(negedge core_clk);
		chk("pe6_test", {7'h00, alt[2]}, {7'h00, e_out[6]});
		chk("pe7_dbe", {7'h00, alt[0]}, {7'h00, e_out[7]});
		wr(IDX_EASSIGN, 8'h60);
		@(negedge core_clk);
		chk("pipe", {6'h00, alt[4:3]}, {6'h00, e_out[6:5]});
		$display("test special modes done");
	endtask : t_spec

	task automatic t_kport();
		do_reset(MODE_NORM_SINGLE, 1'b1, 1'b0);
		wr(IDX_KDIR, 8'hFF);
		wr(IDX_KDATA, 8'h8F);
		@(negedge core_clk);
		chk("k_gpio", 8'h8F, k_out);
		do_reset(MODE_NORM_EXP, 1'b1, 1'b1);
		wr(IDX_KDIR, 8'hFF);
		wr(IDX_KDATA, 8'h0F);
		rdc("k_hidden", IDX_KDATA, 8'h00);
		@(negedge core_clk);
		chk("k_emul", {alt[6], 4'h0, alt[7:5]}, k_out & 8'h8F);
		chk("k_oe", 8'h8F, k_oe);
		wr(IDX_EDIR, 8'hFC);
		rdc("edir_emul", IDX_EDIR, 8'h00);
		$display("test port k done");
	endtask : t_kport

	task automatic t_periph();
		do_reset(MODE_PERIPH, 1'b0, 1'b0);
		wr(IDX_RDRV, 8'h02);
		rdc("rdrv_periph", IDX_RDRV, 8'h00);
		wr(IDX_EDIR, 8'hFC);
		rdc("edir_periph", IDX_EDIR, 8'h00);
		rdc("ea_periph", IDX_EASSIGN, 8'h00);
		@(negedge core_clk);
		chk("rdj_periph", 8'h00, {7'h00, rdj});
		chk("e_clk_in", 8'h00, {7'h00, ecl_oe});
		chk("pe6_periph", {7'h00, alt[2]}, {7'h00, e_out[6]});
		$display("test peripheral done");
	endtask : t_periph

	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = 3'h2;
		op_mode = MODE_NORM_SINGLE;
		ke = 1'b0;
		ee = 1'b0;
		j_ext = 8'hFF;
		e_ext = 8'h03;
		do_reset(MODE_NORM_SINGLE, 1'b0, 1'b0);
		t_reg();
		t_jport();
		t_spec();
		t_kport();
		t_periph();
		close_out();
	end
endmodule : port_pin_control_test
`default_nettype wire

// >>> dv/ppc_pin_model.sv
/*
 * Pin-side partner: resolves port pin levels and feeds alternate sources.
 * Assumes the bench steers outside pin levels right after core_clk edges.
 */
`default_nettype none
module ppc_pin_model (
	// Clock
	input wire logic core_clk,
	// Block drive and outside drive
	input wire logic [7:0] j_out,
	input wire logic [7:0] j_oe,
	input wire logic [7:0] j_ext,
	input wire logic [7:0] k_out,
	input wire logic [7:0] k_oe,
	input wire logic [7:0] e_out,
	input wire logic [7:0] e_oe,
	input wire logic [7:0] e_ext,
	// Resolved levels and alternate sources
	output logic [7:0] j_pin,
	output logic [7:0] k_pin,
	output logic [7:0] e_pin,
	output logic [7:0] alt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg = 8'h00;
	// Own drive wins, so edges on driven pins still reach the detector
	assign j_pin = (j_oe & j_out) | (~j_oe & j_ext);
	// Undriven K pins float: show the inverse, never a stale copy
	assign k_pin = (k_oe & k_out) | (~k_oe & ~k_out);
	assign e_pin = (e_oe & e_out) | (~e_oe & e_ext);
	// Sources come from a counter that steps every cycle; alt[0] toggles each cycle, upper bits more slowly
	always @(posedge core_clk) cnt_reg <= cnt_reg + 8'h01;
	assign alt = cnt_reg ^ 8'h5A;
endmodule : ppc_pin_model
`default_nettype wire

// >>> inc/ppc_pkg.sv
/*
 * Package for the port pin control block: register indices, field
 * positions, reset values, operating modes and the bus request carrier.
 * Assumes a 32-bit AHB-Lite slave port, one register per aligned word.
 */
`default_nettype none
package ppc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_EDATA = 8'h08;
	localparam logic [7:0] IDX_EDIR = 8'h09;
	localparam logic [7:0] IDX_EASSIGN = 8'h0A;
	localparam logic [7:0] IDX_PULL = 8'h0C;
	localparam logic [7:0] IDX_RDRV = 8'h0D;
	localparam logic [7:0] IDX_JDATA = 8'h28;
	localparam logic [7:0] IDX_JDIR = 8'h29;
	localparam logic [7:0] IDX_JPOL = 8'h2A;
	localparam logic [7:0] IDX_JIEN = 8'h2B;
	localparam logic [7:0] IDX_JFLAG = 8'h2C;
	localparam logic [7:0] IDX_KDATA = 8'hFC;
	localparam logic [7:0] IDX_KDIR = 8'hFD;
	// Port E assignment fields
	localparam int EA_DATA_BUS_ENABLE_DISABLE = 7;
	localparam int EA_CLOCK_GEN_TEST_ENABLE = 6;
	localparam int EA_PIPE_STATUS_OUT_ENABLE = 5;
	localparam int EA_E_CLOCK_DISABLE = 4;
	localparam int EA_CALIBRATION_OUT_ENABLE = 3;
	// Pull control and reduced drive fields
	localparam int PULL_J = 7;
	localparam int PULL_E = 4;
	localparam int RDRV_J = 1;
	localparam int RDRV_H = 0;
	// Masks and reset values
	localparam logic [7:0] E_DIR_MASK = 8'hFC;
	localparam logic [7:0] E_PULL_MASK = 8'h8F;
	localparam logic [7:0] K_EMUL_MASK = 8'h87;
	localparam logic [7:0] K_IMPL_MASK = 8'h8F;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int READ_WAIT_CYCLES = 1;

	typedef enum logic [2:0] {
		MODE_NORM_SINGLE = 3'b000,
		MODE_NORM_EXP = 3'b001,
		MODE_SPEC_SINGLE = 3'b010,
		MODE_SPEC_EXP = 3'b011,
		MODE_PERIPH = 3'b100
	} ppc_mode_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] idx;
	} ppc_bus_req_t;
endpackage : ppc_pkg
`default_nettype wire

// >>> verilog/ppc_port_ctrl.sv
/*
 * Port J, K and E pin control with AHB-Lite register slave.
 * Assumes pins and mode inputs are synchronous to core_clk; mode and the
 * two emulation enables come from the chip's mode logic.
 */
`default_nettype none
module ppc_port_ctrl
	import ppc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Operating mode
	input wire logic [2:0] op_mode,
	input wire logic page_index_emul_enable,
	input wire logic eport_emul_enable,
	// Port J pins
	input wire logic [7:0] jport_in,
	output logic [7:0] jport_out,
	output logic [7:0] jport_oe,
	output logic [7:0] jport_pull_on,
	output logic [7:0] jport_pull_down,
	output logic jport_reduced_drive,
	output logic hport_reduced_drive,
	output logic jport_wake_irq,
	// Port K pins and emulation sources
	input wire logic [7:0] kport_in,
	output logic [7:0] kport_out,
	output logic [7:0] kport_oe,
	input wire logic emul_chip_select,
	input wire logic [2:0] page_index,
	// Port E pins and alternate sources
	input wire logic [7:0] eport_in,
	output logic [7:0] eport_out,
	output logic [7:0] eport_oe,
	output logic [7:0] eport_pull_on,
	input wire logic data_enable_pin,
	input wire logic calibration_sig,
	input wire logic clock_test_sig,
	input wire logic [1:0] pipe_status,
	// E clock pin
	input wire logic e_clock_sig,
	output logic e_clock_out,
	output logic e_clock_oe
);
	ppc_mode_t mode;
	logic is_periph, is_exp, is_special, is_norm_single;
	logic k_emul_on, pipe_on, cgm_on, dbe_on;
	logic map_rdrv, map_eassign, map_edir, map_kdata;
	logic [7:0] wake_edge, rd_val;
	logic [7:0] wdat;
	logic acc;

	ppc_bus_req_t req_reg, req_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0] jdata_reg, jdata_next, jdir_reg, jdir_next;
	logic [7:0] jpol_reg, jpol_next, jien_reg, jien_next;
	logic [7:0] jflag_reg, jflag_next, jprev_reg, jprev_next;
	logic [7:0] kdata_reg, kdata_next, kdir_reg, kdir_next;
	logic [7:0] edata_reg, edata_next, edir_reg, edir_next;
	logic [7:0] ea_reg, ea_next, pull_reg, pull_next;
	logic [7:0] rdrv_reg, rdrv_next;
	logic rdrv_lock_reg, rdrv_lock_next;
	logic ea_lock_reg, ea_lock_next;

	assign mode = ppc_mode_t'(op_mode);
	assign is_periph = (mode == MODE_PERIPH);
	assign is_exp = (mode == MODE_NORM_EXP) || (mode == MODE_SPEC_EXP);
	assign is_special = (mode == MODE_SPEC_SINGLE) || (mode == MODE_SPEC_EXP);
	assign is_norm_single = (mode == MODE_NORM_SINGLE);

	// Pin function selection
	assign k_emul_on = page_index_emul_enable && (is_exp || is_periph);
	assign pipe_on = ea_reg[EA_PIPE_STATUS_OUT_ENABLE] && is_exp;
	assign cgm_on = ea_reg[EA_CLOCK_GEN_TEST_ENABLE] && (mode == MODE_SPEC_EXP || is_periph);
	assign dbe_on = !ea_reg[EA_DATA_BUS_ENABLE_DISABLE] && is_exp;

	// Address map visibility
	assign map_rdrv = !is_periph;
	assign map_eassign = !is_periph;
	assign map_edir = !(is_periph || (is_exp && eport_emul_enable));
	assign map_kdata = !k_emul_on;

	// Port J: edges seen on the pin itself, so outputs also wake
	for (genvar gi = 0; gi < 8; gi++) begin : g_wake
		assign wake_edge[gi] = jpol_reg[gi]
			? (jport_in[gi] && !jprev_reg[gi])
			: (!jport_in[gi] && jprev_reg[gi]);
	end
	assign jport_oe = jdir_reg;
	assign jport_out = jdata_reg;
	assign jport_pull_on = {8{pull_reg[PULL_J]}} & ~jdir_reg;
	assign jport_pull_down = jpol_reg;
	assign jport_reduced_drive = rdrv_reg[RDRV_J];
	assign hport_reduced_drive = rdrv_reg[RDRV_H];
	assign jport_wake_irq = |(jflag_reg & jien_reg);

	// Port K: data latch kept, emulation pins take the emulation value
	always_comb begin
		kport_oe = kdir_reg & K_IMPL_MASK;
		kport_out = kdata_reg & K_IMPL_MASK;
		if (k_emul_on) begin
			kport_oe = kport_oe | K_EMUL_MASK;
			kport_out = (kport_out & ~K_EMUL_MASK)
				| {emul_chip_select, 4'h0, page_index};
		end
	end

	// Port E pin functions: on bit 7 data enable beats calibration, on bit 6 pipe status (last) beats clock test
	always_comb begin
		eport_oe = edir_reg & E_DIR_MASK;
		eport_out = edata_reg & E_DIR_MASK;
		if (dbe_on) begin
			eport_oe[7] = 1'b1;
			eport_out[7] = data_enable_pin;
		end else if (ea_reg[EA_CALIBRATION_OUT_ENABLE]) begin
			eport_oe[7] = 1'b1;
			eport_out[7] = calibration_sig;
		end
		if (cgm_on) begin
			eport_oe[6] = 1'b1;
			eport_out[6] = clock_test_sig;
		end
		if (pipe_on) begin
			eport_oe[6:5] = 2'b11;
			eport_out[6:5] = pipe_status;
		end
	end
	assign eport_pull_on = {8{pull_reg[PULL_E]}} & E_PULL_MASK & ~eport_oe;
	assign e_clock_oe = !is_periph;
	assign e_clock_out = ea_reg[EA_E_CLOCK_DISABLE] ? 1'b0 : e_clock_sig;

	// Register read mux; reads of pin ports show the pin when input
	always_comb begin
		rd_val = RST_BYTE;
		case (req_reg.idx)
			IDX_JDATA: rd_val = (jdata_reg & jdir_reg) | (jport_in & ~jdir_reg);
			IDX_JDIR: rd_val = jdir_reg;
			IDX_JPOL: rd_val = jpol_reg;
			IDX_JIEN: rd_val = jien_reg;
			IDX_JFLAG: rd_val = jflag_reg;
			IDX_PULL: rd_val = pull_reg;
			IDX_RDRV: rd_val = map_rdrv ? rdrv_reg : RST_BYTE;
			IDX_KDATA: rd_val = map_kdata
				? ((kdata_reg & kdir_reg) | (kport_in & ~kdir_reg)) & K_IMPL_MASK
				: RST_BYTE;
			IDX_KDIR: rd_val = kdir_reg & K_IMPL_MASK;
			IDX_EDATA: rd_val = (eport_out & eport_oe) | (eport_in & ~eport_oe);
			IDX_EDIR: rd_val = map_edir ? (edir_reg & E_DIR_MASK) : RST_BYTE;
			IDX_EASSIGN: rd_val = map_eassign ? ea_reg : RST_BYTE;
			default: rd_val = RST_BYTE;
		endcase
	end

	// Next state of bus slave and all registers
	always_comb begin
		req_next = req_reg;
		hrdata_next = hrdata_reg;
		jdata_next = jdata_reg;
		jdir_next = jdir_reg;
		jpol_next = jpol_reg;
		jien_next = jien_reg;
		jprev_next = jport_in;
		kdata_next = kdata_reg;
		kdir_next = kdir_reg;
		edata_next = edata_reg;
		edir_next = edir_reg;
		ea_next = ea_reg;
		pull_next = pull_reg;
		rdrv_next = rdrv_reg;
		rdrv_lock_next = rdrv_lock_reg;
		ea_lock_next = ea_lock_reg;
		wdat = hwdata[7:0];
		acc = 1'b0;
		// Sticky wake flags, new edge beats a clear in the same cycle
		jflag_next = jflag_reg | wake_edge;
		if (req_reg.valid && req_reg.write) begin
			case (req_reg.idx)
				IDX_JDATA: jdata_next = wdat;
				IDX_JDIR: jdir_next = wdat;
				IDX_JPOL: jpol_next = wdat;
				IDX_JIEN: jien_next = wdat;
				IDX_JFLAG: jflag_next = (jflag_reg & ~wdat) | wake_edge;
				IDX_PULL: pull_next = wdat;
				IDX_RDRV: begin
					if (map_rdrv && !rdrv_lock_reg) begin
						rdrv_next = wdat;
						rdrv_lock_next = 1'b1;
					end
				end
				IDX_KDATA: begin
					if (map_kdata) begin
						kdata_next = wdat;
					end
				end
				IDX_KDIR: kdir_next = wdat;
				IDX_EDATA: edata_next = wdat;
				IDX_EDIR: begin
					if (map_edir) begin
						edir_next = wdat & E_DIR_MASK;
					end
				end
				IDX_EASSIGN: begin
					if (map_eassign) begin
						ea_lock_next = 1'b1;
						acc = is_special ? ea_lock_reg : !ea_lock_reg;
						if (acc) begin
							ea_next[EA_DATA_BUS_ENABLE_DISABLE] = wdat[EA_DATA_BUS_ENABLE_DISABLE];
							ea_next[EA_PIPE_STATUS_OUT_ENABLE] = wdat[EA_PIPE_STATUS_OUT_ENABLE];
						end
						if (is_special && ea_lock_reg) begin
							ea_next[EA_CLOCK_GEN_TEST_ENABLE] = wdat[EA_CLOCK_GEN_TEST_ENABLE];
						end
						if (mode == MODE_SPEC_SINGLE
							|| (is_norm_single && !ea_lock_reg)) begin
							ea_next[EA_E_CLOCK_DISABLE] = wdat[EA_E_CLOCK_DISABLE];
						end
						ea_next[EA_CALIBRATION_OUT_ENABLE] = wdat[EA_CALIBRATION_OUT_ENABLE];
					end
				end
				default: ;
			endcase
		end
		// One wait state on reads lets a prior write land first
		if (req_reg.valid && !req_reg.write) begin
			hrdata_next = {24'h00_0000, rd_val};
		end
		if (hready) begin
			req_next.valid = hsel && htrans[1];
			req_next.write = hwrite;
			req_next.idx = haddr[9:2];
			if (haddr[31:10] != 22'h00_0000) begin
				req_next.idx = 8'hFF;
			end
		end else begin
			req_next.valid = 1'b0;
		end
		if (sys_rst) begin
			req_next = '0;
			hrdata_next = 32'h0000_0000;
			jdata_next = RST_BYTE;
			jdir_next = RST_BYTE;
			jpol_next = RST_BYTE;
			jien_next = RST_BYTE;
			jflag_next = RST_BYTE;
			kdata_next = RST_BYTE;
			kdir_next = RST_BYTE;
			edata_next = RST_BYTE;
			edir_next = RST_BYTE;
			pull_next = RST_BYTE;
			rdrv_next = RST_BYTE;
			rdrv_lock_next = 1'b0;
			ea_lock_next = 1'b0;
			ea_next = RST_BYTE;
			ea_next[EA_CLOCK_GEN_TEST_ENABLE] = is_periph;
		end
	end

	always_ff @(posedge core_clk) begin
		req_reg <= req_next;
		hrdata_reg <= hrdata_next;
		jdata_reg <= jdata_next;
		jdir_reg <= jdir_next;
		jpol_reg <= jpol_next;
		jien_reg <= jien_next;
		jflag_reg <= jflag_next;
		jprev_reg <= jprev_next;
		kdata_reg <= kdata_next;
		kdir_reg <= kdir_next;
		edata_reg <= edata_next;
		edir_reg <= edir_next;
		ea_reg <= ea_next;
		pull_reg <= pull_next;
		rdrv_reg <= rdrv_next;
		rdrv_lock_reg <= rdrv_lock_next;
		ea_lock_reg <= ea_lock_next;
	end

	// Read data phase stalls while the answer is being registered
	assign hreadyout = !(req_reg.valid && !req_reg.write);
	assign hrdata = hrdata_reg;
	assign hresp = 1'b0;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence seq_rd_accept(logic [7:0] idx);
		hsel && htrans[1] && !hwrite && hready && haddr[9:2] == idx
			&& haddr[31:10] == 22'h00_0000;
	endsequence
	sequence seq_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence seq_wr(logic [7:0] idx);
		req_reg.valid && req_reg.write && req_reg.idx == idx;
	endsequence

	a_wake_flag_set: assert property (
		(wake_edge != 8'h00) |=> ((jflag_reg & $past(wake_edge))
			== $past(wake_edge)))
		else $error("Wake edge did not set its flag");
	a_wake_irq_gate: assert property (
		((jflag_reg & jien_reg) == 8'h00) |-> !jport_wake_irq)
		else $error("Wake interrupt without enabled flag");
	a_rdrv_once: assert property (
		(seq_wr(IDX_RDRV) and rdrv_lock_reg) |=> $stable(rdrv_reg))
		else $error("Reduced drive rewritten after lock");
	a_kbit3_gpio: assert property (
		kport_oe[3] == kdir_reg[3] && kport_out[3] == kdata_reg[3])
		else $error("Port K bit 3 took an emulation role");
	a_kemul_pins: assert property (
		k_emul_on |-> kport_out[2:0] == page_index
			&& kport_out[7] == emul_chip_select)
		else $error("Emulation pin followed data latch");
	a_eirq_input: assert property (
		eport_oe[1:0] == 2'b00)
		else $error("Port E interrupt pin driven");
	a_eport_assignment_hidden: assert property (
		(seq_rd_accept(IDX_EASSIGN) and is_periph) ##1 seq_rd_answer
			|-> hrdata == 32'h0000_0000)
		else $error("Assignment readable in peripheral mode");
	a_read_wait: assert property (
		seq_rd_accept(IDX_EDIR) |=> seq_rd_answer)
		else $error("Read answer timing wrong");
	a_clock_gen_test_enable_normal: assert property (
		(seq_wr(IDX_EASSIGN) and !is_special) |=> $stable(ea_reg[EA_CLOCK_GEN_TEST_ENABLE]))
		else $error("Clock test enable written in normal mode");
	a_pipe_priority: assert property (
		pipe_on |-> eport_out[6] == pipe_status[1] && eport_oe[6])
		else $error("Pipe status lost priority on bit 6");
	a_edir_hidden: assert property (
		(seq_wr(IDX_EDIR) and !map_edir) |=> $stable(edir_reg))
		else $error("Hidden port E direction register written");
	a_rdrv_hidden: assert property (
		(seq_wr(IDX_RDRV) and is_periph) |=> $stable(rdrv_reg))
		else $error("Reduced drive written in peripheral mode");
endmodule : ppc_port_ctrl
`default_nettype wire
